// ==== usrb_port.v ====
// Shadow receive/transmit data port with FIFOs, status and interrupt.
`default_nettype none
`include "usrb_defs.vh"
// Contract
// - Sixteen aliased 32-bit words all reach the same receive/transmit path.
// - Data read returns byte from serial input, or infrared input in IR mode.
// - Read data valid only while data-ready flag is set; reader checks it.
// - FIFOs off: new byte overwrites unread one and flags overrun.
// - FIFOs on: a read returns the oldest receive FIFO entry.
// - Receive FIFO full: keep contents, drop new byte, flag overrun.
// - Write queues byte to serial output, or active-low IR output.
// - FIFOs off: one write clears transmit-holding-empty flag.
// - FIFOs off: later writes before flag returns overwrite pending byte.
// - FIFOs on: accept writes up to depth 16 before full.
// - Write while transmit FIFO full is dropped, contents unchanged.
module usrb_port (
   // Clock and reset.
   input wire clk_i,
   input wire rst_n_i,
   // APB slave.
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [31:0] paddr_i,
   input wire [31:0] pwdata_i,
   output reg [31:0] prdata_o,
   output reg pready_o,
   output reg pslverr_o,
   // Serial pins.
   input wire sin_i,
   input wire ir_in_i,
   output reg sout_o,
   output reg ir_out_n_o,
   // Interrupt.
   output reg irq_o
);
   // ****************************************************************
   // Declarations
   // ****************************************************************
   reg [1:0] sin_sync;
   reg [1:0] ir_sync;
   reg [1:0] ctrl;
   reg [7:0] rx_hold;
   reg rx_hold_full;
   reg [7:0] tx_hold;
   reg tx_hold_full;
   reg overrun;
   reg [3:0] irq_stat;
   reg [3:0] irq_mask;
   reg tx_empty_q;
   reg [31:0] next_rdata;
   wire fifo_en;
   wire ir_mode;
   wire rx_line;
   wire ser_rx_valid;
   wire [7:0] ser_rx_data;
   wire ser_tx_ready;
   wire ser_tx_line;
   wire [7:0] rxf_head;
   wire rxf_empty;
   wire rxf_full;
   wire [7:0] txf_head;
   wire txf_empty;
   wire txf_full;
   wire access;
   wire wr_acc;
   wire rd_acc;
   wire hit_data;
   wire data_wr;
   wire data_rd;
   wire data_ready;
   wire tx_empty;
   wire rx_push;
   wire tx_push;
   wire ctrl_wr;
   wire mapped;
   wire rx_ovr_ev;
   wire tx_drop_ev;
   wire [3:0] ev;

   // True when the address falls in the aliased data window.
   function is_alias;
      input [31:0] a;
      begin
         is_alias = (a >= `USRB_ALIAS_BASE) &&
            (a < `USRB_ALIAS_BASE + 4 * `USRB_ALIAS_COUNT) &&
            (a[1:0] == 2'h0);
      end
   endfunction

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   // Both receive pins pass two flops before any use.
   // Each flop resets to its pin's idle level, so that no false start
   // bit is seen in the first cycles after reset.
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         sin_sync <= 2'h3;
         ir_sync <= 2'h0;
      end else begin
         sin_sync <= {sin_sync[0], sin_i};
         ir_sync <= {ir_sync[0], ir_in_i};
      end
   end

   // Control bits are named once here so every path reads the same mode.
   assign fifo_en = ctrl[`USRB_CTRL_FIFO_EN];
   assign ir_mode = ctrl[`USRB_CTRL_IR_MODE];
   // input select
   // The IR input idles low and pulses high, so it is inverted here.
   assign rx_line = ir_mode ? ~ir_sync[1] : sin_sync[1];

   // ****************************************************************
   // Bus decode
   // ****************************************************************
   // Every access completes in its second access cycle, after one wait state.
   assign access = psel_i && penable_i && !pready_o;
   assign wr_acc = access && pwrite_i;
   assign rd_acc = access && !pwrite_i;
   // alias decode
   // All sixteen words decode to the one data path.
   assign hit_data = is_alias(paddr_i);
   assign data_wr = wr_acc && hit_data;
   assign data_rd = rd_acc && hit_data;
   assign ctrl_wr = wr_acc && (paddr_i == `USRB_CTRL_ADDR);
   assign mapped = hit_data || (paddr_i == `USRB_CTRL_ADDR) ||
      (paddr_i == `USRB_STAT_ADDR) || (paddr_i == `USRB_IRQ_STAT_ADDR) ||
      (paddr_i == `USRB_IRQ_MASK_ADDR);

   // ****************************************************************
   // Receive path
   // ****************************************************************
   usrb_serial u_serial (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .tx_valid_i(tx_hold_full | ~txf_empty),
      .tx_data_i(fifo_en ? txf_head : tx_hold),
      .tx_ready_o(ser_tx_ready),
      .tx_line_o(ser_tx_line),
      .rx_line_i(rx_line),
      .rx_valid_o(ser_rx_valid),
      .rx_data_o(ser_rx_data)
   );

   // full receive FIFO refuses the byte
   assign rx_push = ser_rx_valid && fifo_en;
   usrb_fifo u_rx_fifo (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .push_i(rx_push),
      .push_data_i(ser_rx_data),
      .pop_i(data_rd && fifo_en),
      .head_o(rxf_head),
      .empty_o(rxf_empty),
      .full_o(rxf_full),
      .flush_i(ctrl_wr)
   );

   assign data_ready = fifo_en ? !rxf_empty : rx_hold_full;
   assign rx_ovr_ev = ser_rx_valid && (fifo_en ? rxf_full : rx_hold_full);

   // single holding byte overwritten, overrun flagged
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         rx_hold <= `USRB_DATA_RST;
         rx_hold_full <= 1'b0;
      end else if (ser_rx_valid && !fifo_en) begin
         rx_hold <= ser_rx_data;
         rx_hold_full <= 1'b1;
      end else if (data_rd && !fifo_en) begin
         rx_hold_full <= 1'b0;
      end
   end

   // ****************************************************************
   // Transmit path
   // ****************************************************************
   // full transmit FIFO drops the write
   assign tx_push = data_wr && fifo_en;
   assign tx_drop_ev = tx_push && txf_full;
   usrb_fifo u_tx_fifo (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .push_i(tx_push),
      .push_data_i(pwdata_i[7:0]),
      .pop_i(ser_tx_ready && fifo_en),
      .head_o(txf_head),
      .empty_o(txf_empty),
      .full_o(txf_full),
      .flush_i(ctrl_wr)
   );

   // A write in the cycle the shifter takes the byte wins, so that new
   // byte is kept pending rather than lost.
   // write clears empty; a later write overwrites the byte
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         tx_hold <= `USRB_DATA_RST;
         tx_hold_full <= 1'b0;
      end else if (data_wr && !fifo_en) begin
         tx_hold <= pwdata_i[7:0];
         tx_hold_full <= 1'b1;
      end else if (ser_tx_ready || fifo_en) begin
         tx_hold_full <= 1'b0;
      end
   end

   // FIFO mode: empty only when no bytes wait
   assign tx_empty = fifo_en ? txf_empty : !tx_hold_full;

   // route to serial or active-low IR output
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         sout_o <= 1'b1;
         ir_out_n_o <= 1'b1;
      end else begin
         sout_o <= ir_mode ? 1'b1 : ser_tx_line;
         ir_out_n_o <= ir_mode ? ser_tx_line : 1'b1;
      end
   end

   // ****************************************************************
   // Control, status and interrupts
   // ****************************************************************
   // The empty flag is delayed one cycle so that only its rising edge
   // counts as an event; it resets high so reset itself is not reported.
   assign ev = {tx_drop_ev, tx_empty && !tx_empty_q, rx_ovr_ev,
      ser_rx_valid};

   // Sticky flags: a new event wins over the clearing read.
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         ctrl <= `USRB_CTRL_RST;
         irq_mask <= 4'h0;
         irq_stat <= 4'h0;
         overrun <= 1'b0;
         tx_empty_q <= 1'b1;
         irq_o <= 1'b0;
      end else begin
         tx_empty_q <= tx_empty;
         if (ctrl_wr) begin
            ctrl <= pwdata_i[1:0];
         end
         if (wr_acc && paddr_i == `USRB_IRQ_MASK_ADDR) begin
            irq_mask <= pwdata_i[3:0];
         end
         if (rd_acc && paddr_i == `USRB_IRQ_STAT_ADDR) begin
            irq_stat <= ev;
         end else begin
            irq_stat <= irq_stat | ev;
         end
         // overrun flag, cleared by status read
         if (rx_ovr_ev) begin
            overrun <= 1'b1;
         end else if (rd_acc && paddr_i == `USRB_STAT_ADDR) begin
            overrun <= 1'b0;
         end
         // Looking ahead at ev keeps the pin in step with the status bits.
         irq_o <= |((irq_stat | ev) & irq_mask) &&
            !(rd_acc && paddr_i == `USRB_IRQ_STAT_ADDR && ~|(ev & irq_mask));
      end
   end

   // Reading data when no byte is ready returns the stale byte; software
   // must check the data-ready flag first.
   // read mux, upper bits zero
   always @* begin
      next_rdata = 32'h00000000;
      if (hit_data) begin
         // head of FIFO in FIFO mode
         next_rdata[7:0] = fifo_en ? rxf_head : rx_hold;
      end else if (paddr_i == `USRB_CTRL_ADDR) begin
         next_rdata[1:0] = ctrl;
      end else if (paddr_i == `USRB_STAT_ADDR) begin
         next_rdata[`USRB_LS_DATA_READY] = data_ready;
         next_rdata[`USRB_LS_OVERRUN] = overrun;
         next_rdata[`USRB_LS_TX_EMPTY] = tx_empty;
      end else if (paddr_i == `USRB_IRQ_STAT_ADDR) begin
         next_rdata[3:0] = irq_stat;
      end else if (paddr_i == `USRB_IRQ_MASK_ADDR) begin
         next_rdata[3:0] = irq_mask;
      end
   end

   // One wait state: pready the cycle after the first access-phase cycle.
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         prdata_o <= 32'h00000000;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
      end else begin
         pready_o <= access;
         pslverr_o <= access && !mapped;
         if (rd_acc) begin
            prdata_o <= next_rdata;
         end
      end
   end
endmodule
`default_nettype wire

// ==== usrb_defs.vh ====
// Constants for the shadow receive/transmit data port of the UART.
`ifndef USRB_DEFS_VH
`define USRB_DEFS_VH
// Sixteen aliased data words start here (byte addresses).
`define USRB_ALIAS_BASE 32'h50001030
`define USRB_ALIAS_7 32'h5000104C
`define USRB_ALIAS_8 32'h50001050
`define USRB_ALIAS_COUNT 16
// Control, status and interrupt registers.
`define USRB_CTRL_ADDR 32'h50001080
`define USRB_STAT_ADDR 32'h50001084
`define USRB_IRQ_STAT_ADDR 32'h50001088
`define USRB_IRQ_MASK_ADDR 32'h5000108C
// Control bit positions.
`define USRB_CTRL_FIFO_EN 0
`define USRB_CTRL_IR_MODE 1
// Line status bit positions.
`define USRB_LS_DATA_READY 0
`define USRB_LS_OVERRUN 1
`define USRB_LS_TX_EMPTY 5
// Interrupt event bit positions.
`define USRB_EV_RX 0
`define USRB_EV_OVR 1
`define USRB_EV_TXE 2
`define USRB_EV_DROP 3
// FIFO depth and pointer width.
`define USRB_FIFO_DEPTH 16
`define USRB_PTR_W 4
`define USRB_CNT_W 5
// Serial bit time in clock cycles.
`define USRB_BIT_CYC 8'h10
// Reset values.
`define USRB_DATA_RST 8'h00
`define USRB_CTRL_RST 2'h0
`endif

// ==== usrb_fifo.v ====
// Byte FIFO of fixed depth, held in flip-flops.
`default_nettype none
`include "usrb_defs.vh"
module usrb_fifo (
   // Clock and reset.
   input wire clk_i,
   input wire rst_n_i,
   // Push side.
   input wire push_i,
   input wire [7:0] push_data_i,
   // Pop side.
   input wire pop_i,
   output wire [7:0] head_o,
   output wire empty_o,
   output wire full_o,
   // Flush.
   input wire flush_i
);
   reg [7:0] mem [0:`USRB_FIFO_DEPTH-1];
   reg [`USRB_PTR_W-1:0] rd_ptr;
   reg [`USRB_PTR_W-1:0] wr_ptr;
   reg [`USRB_CNT_W-1:0] count;
   wire do_push;
   wire do_pop;

   // Full refuses a push; the caller flags the loss.
   assign full_o = (count == `USRB_FIFO_DEPTH);
   assign empty_o = (count == {`USRB_CNT_W{1'b0}});
   assign head_o = mem[rd_ptr];
   assign do_push = push_i && !full_o;
   assign do_pop = pop_i && !empty_o;

   // Pointers and occupancy.
   always @(posedge clk_i) begin
      if (!rst_n_i || flush_i) begin
         rd_ptr <= {`USRB_PTR_W{1'b0}};
         wr_ptr <= {`USRB_PTR_W{1'b0}};
         count <= {`USRB_CNT_W{1'b0}};
      end else begin
         if (do_push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (do_pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (do_push && !do_pop) begin
            count <= count + 1'b1;
         end else if (do_pop && !do_push) begin
            count <= count - 1'b1;
         end
      end
   end

   // Storage is not reset; contents matter only while counted.
   always @(posedge clk_i) begin
      if (do_push) begin
         mem[wr_ptr] <= push_data_i;
      end
   end
endmodule
`default_nettype wire

// ==== usrb_serial.v ====
// Simple 8N1 serial transmitter and receiver, one bit per clock divider.
`default_nettype none
`include "usrb_defs.vh"
module usrb_serial (
   // Clock and reset.
   input wire clk_i,
   input wire rst_n_i,
   // Transmit byte handshake.
   input wire tx_valid_i,
   input wire [7:0] tx_data_i,
   output reg tx_ready_o,
   output reg tx_line_o,
   // Receive, line already synchronised.
   input wire rx_line_i,
   output reg rx_valid_o,
   output reg [7:0] rx_data_o
);
   localparam [7:0] BIT_CYC = `USRB_BIT_CYC;
   reg [7:0] tx_div;
   reg [3:0] tx_bit;
   reg [9:0] tx_sh;
   reg tx_busy;
   reg [7:0] rx_div;
   reg [3:0] rx_bit;
   reg [8:0] rx_sh;
   reg rx_busy;

   // Transmitter shifts start, eight data bits and stop.
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         tx_div <= 8'h00;
         tx_bit <= 4'h0;
         tx_sh <= 10'h3FF;
         tx_busy <= 1'b0;
         tx_ready_o <= 1'b0;
         tx_line_o <= 1'b1;
      end else begin
         tx_ready_o <= 1'b0;
         if (!tx_busy) begin
            tx_line_o <= 1'b1;
            if (tx_valid_i && !tx_ready_o) begin
               tx_ready_o <= 1'b1;
               tx_busy <= 1'b1;
               tx_sh <= {1'b1, tx_data_i, 1'b0};
               tx_bit <= 4'h0;
               tx_div <= 8'h00;
            end
         end else begin
            tx_line_o <= tx_sh[0];
            if (tx_div == BIT_CYC - 8'h01) begin
               tx_div <= 8'h00;
               tx_sh <= {1'b1, tx_sh[9:1]};
               tx_bit <= tx_bit + 4'h1;
               if (tx_bit == 4'h9) begin
                  tx_busy <= 1'b0;
               end
            end else begin
               tx_div <= tx_div + 8'h01;
            end
         end
      end
   end

   // Receiver samples mid bit after a falling start edge.
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         rx_div <= 8'h00;
         rx_bit <= 4'h0;
         rx_sh <= 9'h000;
         rx_busy <= 1'b0;
         rx_valid_o <= 1'b0;
         rx_data_o <= 8'h00;
      end else begin
         rx_valid_o <= 1'b0;
         if (!rx_busy) begin
            if (!rx_line_i) begin
               rx_busy <= 1'b1;
               rx_div <= BIT_CYC >> 1;
               rx_bit <= 4'h0;
            end
         end else if (rx_div == BIT_CYC - 8'h01) begin
            rx_div <= 8'h00;
            rx_sh <= {rx_line_i, rx_sh[8:1]};
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == 4'h9) begin
               rx_busy <= 1'b0;
               rx_valid_o <= rx_line_i;
               rx_data_o <= rx_sh[8:1];
            end
         end else begin
            rx_div <= rx_div + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// ==== usrb_port_props.sv ====
// Concurrent checks on the pins of the shadow data port.
`default_nettype none
`include "usrb_defs.vh"
module usrb_port_props (
   // Clock and reset.
   input wire clk_i,
   input wire rst_n_i,
   // APB slave.
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [31:0] paddr_i,
   input wire [31:0] pwdata_i,
   input wire [31:0] prdata_o,
   input wire pready_o,
   input wire pslverr_o,
   // Serial pins and interrupt.
   input wire sin_i,
   input wire ir_in_i,
   input wire sout_o,
   input wire ir_out_n_o,
   input wire irq_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // Address classes and assertions
   // ****************************************
   // The sixteen data words and the four control words are mapped.
   wire in_alias = paddr_i >= `USRB_ALIAS_BASE &&
      paddr_i < `USRB_ALIAS_BASE + 32'h40 && paddr_i[1:0] == 2'h0;
   wire in_ctl = paddr_i[31:4] == 28'h5000108 && paddr_i[1:0] == 2'h0;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   chk_ready_pulse: assert property (pready_o |=> !pready_o)
      else $error("pready held for more than one cycle");
   chk_one_wait: assert property (
      psel_i && penable_i && !pready_o |=> pready_o)
      else $error("access not answered after one wait cycle");
   chk_no_spurious: assert property (
      pready_o |-> $past(psel_i && penable_i))
      else $error("pready without an access phase");
   chk_err_decode: assert property (
      pready_o |-> pslverr_o == !(in_alias || in_ctl))
      else $error("error response does not match the address map");
   chk_upper_zero: assert property (
      pready_o && !pwrite_i && in_alias |-> prdata_o[31:8] == 24'h0)
      else $error("upper bits of a data word read nonzero");
   // Read data may only move when a read completes.
   chk_rdata_hold: assert property (
      !(pready_o && !pwrite_i) |-> $stable(prdata_o))
      else $error("read data changed outside a read");
   chk_start_bit: assert property (
      $fell(sout_o) |-> (!sout_o) [*8] ##1 (!sout_o) [*8])
      else $error("serial start bit shorter than sixteen clocks");
   chk_ir_start: assert property (
      $fell(ir_out_n_o) |-> (!ir_out_n_o) [*8] ##1 (!ir_out_n_o) [*8])
      else $error("infrared start bit shorter than sixteen clocks");
   chk_one_line: assert property (sout_o || ir_out_n_o)
      else $error("both transmit lines active at once");
endmodule
bind usrb_port usrb_port_props i_props (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
   .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .sin_i(sin_i),
   .ir_in_i(ir_in_i), .sout_o(sout_o), .ir_out_n_o(ir_out_n_o),
   .irq_o(irq_o));
`default_nettype wire

// ==== usrb_far_end.sv ====
// Model of the remote serial or infrared transceiver.
`default_nettype none
module usrb_far_end (
   // Clock.
   input wire logic clk_i,
   // Lines from the port.
   input wire logic sout_i,
   input wire logic ir_out_n_i,
   // Lines to the port.
   output logic sin_o,
   output logic ir_in_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // Frame sender and receiver
   // ****************************************
   localparam int BIT_CLK = 16;
   logic [7:0] rxq[$];
   logic [7:0] sh;
   // Idle lines of both kinds are high, so one AND sees either.
   wire line = sout_i & ir_out_n_i;
   initial begin
      sin_o = 1'b1;
      ir_in_o = 1'b0;
   end
   task automatic send(input logic [7:0] b, input logic ir);
      logic [9:0] fr;
      fr = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         sin_o <= ir ? 1'b1 : fr[i];
         ir_in_o <= ir ? !fr[i] : 1'b0;
         repeat (BIT_CLK) @(posedge clk_i);
      end
   endtask
   always begin
      @(negedge line);
      repeat (BIT_CLK / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CLK) @(posedge clk_i);
         sh[i] = line;
      end
      repeat (BIT_CLK) @(posedge clk_i);
      rxq.push_back(sh);
   end
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the shadow receive/transmit data port.
`default_nettype none
`include "usrb_defs.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [31:0] paddr_i = 32'h0;
   logic [31:0] pwdata_i = 32'h0;
   wire [31:0] prdata_o;
   wire pready_o, pslverr_o, sin_i, ir_in_i, sout_o, ir_out_n_o, irq_o;
   int err_count = 0;
   int checks = 0;
   int cyc = 0;
   logic [31:0] rd;
   logic err;
   always #25 clk_i = ~clk_i;
   usrb_port i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .sin_i(sin_i), .ir_in_i(ir_in_i),
      .sout_o(sout_o), .ir_out_n_o(ir_out_n_o), .irq_o(irq_o));
   usrb_far_end i_far (.clk_i(clk_i), .sout_i(sout_o),
      .ir_out_n_i(ir_out_n_o), .sin_o(sin_i), .ir_in_o(ir_in_i));
   // ****************************************
   // Tasks
   // ****************************************
   task automatic complete_run();
      if (err_count == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e,
         input logic [31:0] g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // One APB transfer; the request stands until pready is sampled.
   task automatic apb(input logic w, input logic [31:0] a,
         input logic [31:0] d);
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      @(posedge clk_i);
      while (pready_o !== 1'b1) @(posedge clk_i);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input string n, input logic [31:0] a,
         input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(n, e, rd & m);
   endtask
   task automatic wait_rx(input int n);
      while (i_far.rxq.size() < n) @(posedge clk_i);
   endtask
   // A hang counts as a mismatch and closes the run.
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         complete_run();
      end
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (5) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rdc("alias7", `USRB_ALIAS_7, 32'hFFFFFFFF, 32'h0);
      rdc("status", `USRB_STAT_ADDR, 32'h23, 32'h20);
      rdc("unmapped", 32'h50001000, 32'hFFFFFFFF, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      // Second write while the shifter is busy, third overwrites it.
      wr(`USRB_ALIAS_7, 32'hDEADBEA5);
      while (sout_o !== 1'b0) @(posedge clk_i);
      wr(`USRB_ALIAS_8, 32'h11);
      rdc("tx_empty", `USRB_STAT_ADDR, 32'h20, 32'h0);
      wr(`USRB_ALIAS_BASE, 32'h3C);
      wait_rx(2);
      chk("tx_first", 32'hA5, {24'h0, i_far.rxq[0]});
      chk("tx_over", 32'h3C, {24'h0, i_far.rxq[1]});
      i_far.rxq.delete();
      // Two bytes unread: the second replaces the first.
      i_far.send(8'h5A, 1'b0);
      i_far.send(8'hC3, 1'b0);
      repeat (40) @(posedge clk_i);
      chk("irq_masked", 32'h0, {31'h0, irq_o});
      rdc("overrun", `USRB_STAT_ADDR, 32'h3, 32'h3);
      rdc("rx_last", `USRB_ALIAS_8, 32'hFFFFFFFF, 32'hC3);
      wr(`USRB_IRQ_MASK_ADDR, 32'h3);
      repeat (2) @(posedge clk_i);
      chk("irq_on", 32'h1, {31'h0, irq_o});
      rdc("irq_stat", `USRB_IRQ_STAT_ADDR, 32'h3, 32'h3);
      repeat (2) @(posedge clk_i);
      chk("irq_off", 32'h0, {31'h0, irq_o});
      // Seventeen bytes into sixteen entries: the last one is lost.
      wr(`USRB_CTRL_ADDR, 32'h1);
      for (int i = 0; i < 17; i++) i_far.send(8'h40 + 8'(i), 1'b0);
      repeat (40) @(posedge clk_i);
      rdc("fifo_ovr", `USRB_STAT_ADDR, 32'h3, 32'h3);
      for (int i = 0; i < 16; i++) rdc("fifo_head",
         `USRB_ALIAS_BASE + 32'(4 * i), 32'hFF, 32'h40 + 32'(i));
      rdc("fifo_empty", `USRB_STAT_ADDR, 32'h1, 32'h0);
      // Eighteen quick writes overfill the transmit side.
      apb(1'b0, `USRB_IRQ_STAT_ADDR, 32'h0);
      for (int i = 0; i < 18; i++) wr(`USRB_ALIAS_BASE +
         32'(4 * (i % 16)), 32'h80 + 32'(i));
      rdc("tx_drop", `USRB_IRQ_STAT_ADDR, 32'h8, 32'h8);
      wait_rx(16);
      for (int i = 0; i < 16; i++) chk("tx_fifo",
         32'h80 + 32'(i), {24'h0, i_far.rxq[i]});
      repeat (200) @(posedge clk_i);
      i_far.rxq.delete();
      // Infrared mode in both directions.
      wr(`USRB_CTRL_ADDR, 32'h3);
      i_far.send(8'h96, 1'b1);
      repeat (40) @(posedge clk_i);
      rdc("ir_rx", `USRB_ALIAS_7, 32'hFF, 32'h96);
      rdc("tx_ready", `USRB_STAT_ADDR, 32'h20, 32'h20);
      wr(`USRB_ALIAS_8, 32'h69);
      wait_rx(1);
      chk("ir_tx", 32'h69, {24'h0, i_far.rxq[0]});
      chk("sout_idle", 32'h1, {31'h0, sout_o});
      complete_run();
   end
endmodule
`default_nettype wire
